// ### vaicc_dev.sv
// slave end: address match, subaddress, three channel configuration registers
`timescale 1ns/1ps
`default_nettype none
module vaicc_dev (
  // two-wire link
  vaicc_if.slave bus,
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // address select pins
  input wire logic addr_select_hi_pin,
  input wire logic addr_select_lo_pin,
  // channel configuration
  output var vaicc_pkg::vaicc_cfg_t ch_cfg,
  output var logic [3:1][1:0] ch_filter,
  output var logic [3:1] ch_input_b,
  output var logic [3:1][2:0] ch_mode,
  output var logic [3:1] ch_enable,
  output var logic [3:1] ch_mute,
  output var logic [3:1] sync_tip_clamp_mode,
  // link status
  output var logic cfg_wr_pulse,
  output var logic [1:0] cfg_wr_ch,
  output var logic dev_addressed
);
  import vaicc_pkg::*;

  // ************************************
  // helpers
  // ************************************

  // subaddress names one of the three channels
  function automatic logic sub_valid(input logic [7:0] s);
    sub_valid = (s == SUB_CH1) || (s == SUB_CH2) || (s == SUB_CH3);
  endfunction

  // register content for a read
  function automatic logic [7:0] pick(input vaicc_cfg_t c, input logic [7:0] s);
    case (s)
      SUB_CH1: pick = c[1];
      SUB_CH2: pick = c[2];
      SUB_CH3: pick = c[3];
      default: pick = RD_BAD;
    endcase
  endfunction

  // filter code, meaningful only in clamp modes
  function automatic logic [1:0] filt_code(input logic [7:0] c);
    if (c[MODE_HI:MODE_LO] < MODE_STC_LO) begin
      filt_code = FILT_NONE;
    end else begin
      case (c[FILT_HI:FILT_LO])
        2'h0: filt_code = FILT_500K;
        2'h1: filt_code = FILT_2M5;
        default: filt_code = FILT_5M;
      endcase
    end
  endfunction

  // ************************************
  // input sampling
  // ************************************
  logic [2:0] scl_ff_r;
  logic [2:0] sda_ff_r;
  logic [2:0] ahi_ff_r;
  logic [2:0] alo_ff_r;
  logic scl_s_r;
  logic sda_s_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [1:0] sel_r;
  logic zero_r;

  // three-stage shift of every pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_ff_r <= SYNC_RST;
      sda_ff_r <= SYNC_RST;
      ahi_ff_r <= 3'h0;
      alo_ff_r <= 3'h0;
    end else begin
      scl_ff_r <= {scl_ff_r[1:0], bus.scl};
      sda_ff_r <= {sda_ff_r[1:0], bus.sda};
      ahi_ff_r <= {ahi_ff_r[1:0], addr_select_hi_pin};
      alo_ff_r <= {alo_ff_r[1:0], addr_select_lo_pin};
    end
  end

  // accept a level once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sel_r <= 2'h0;
      zero_r <= 1'b0;
    end else begin
      if (scl_ff_r[2] == scl_ff_r[1]) begin
        scl_s_r <= scl_ff_r[2];
      end
      if (sda_ff_r[2] == sda_ff_r[1]) begin
        sda_s_r <= sda_ff_r[2];
      end
      if (ahi_ff_r[2] == ahi_ff_r[1]) begin
        sel_r[1] <= ahi_ff_r[2];
      end
      if (alo_ff_r[2] == alo_ff_r[1]) begin
        sel_r[0] <= alo_ff_r[2];
      end
      scl_d_r <= scl_s_r;
      sda_d_r <= sda_s_r;
      zero_r <= 1'b0;
    end
  end

  // ************************************
  // bus events
  // ************************************
  vaicc_dst_t state_r;
  logic [3:0] bitc_r;
  logic [1:0] bidx_r;
  logic [7:0] shreg_r;
  logic [7:0] sub_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic sda_oe_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic addr_hit;
  logic wr_fire;
  logic [7:0] rd_byte;

  // edges and start/stop while scl is high
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_seen = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_seen = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign byte_done = (state_r == D_RX) && scl_fall && (bitc_r == ACK_SLOT);
  // prefix plus live pin levels
  assign addr_hit = (shreg_r[7:1] == {ADDR_PREFIX, sel_r});
  assign wr_fire = byte_done && (bidx_r == BIDX_DATA) && sub_valid(sub_r);
  assign rd_byte = pick(ch_cfg, sub_r);

  assign bus.sda_s_o = zero_r;
  assign bus.sda_s_oe = sda_oe_r;

  // ************************************
  // protocol engine
  // ************************************

  // byte reception, acknowledge and read-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= D_IDLE;
      bitc_r <= 4'h0;
      bidx_r <= BIDX_ADDR;
      shreg_r <= 8'h00;
      sub_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_seen) begin
      state_r <= D_RX;
      bitc_r <= 4'h0;
      bidx_r <= BIDX_ADDR;
      sda_oe_r <= 1'b0;
    end else if (stop_seen) begin
      state_r <= D_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        D_IDLE: begin
          sda_oe_r <= 1'b0; // wait for start
        end
        D_RX: begin
          if (scl_rise && bitc_r != ACK_SLOT) begin
            shreg_r <= {shreg_r[6:0], sda_s_r};
            bitc_r <= bitc_r + 4'h1;
          end
          if (byte_done) begin
            bitc_r <= 4'h0;
            if (bidx_r == BIDX_OVER || (bidx_r == BIDX_ADDR && !addr_hit)) begin
              state_r <= D_IDLE;
            end else begin
              sda_oe_r <= 1'b1;
              state_r <= D_ACK;
              bidx_r <= bidx_r + 2'h1;
              if (bidx_r == BIDX_ADDR) begin
                rw_r <= shreg_r[0];
              end
              if (bidx_r == BIDX_SUB) begin
                sub_r <= shreg_r;
              end
            end
          end
        end
        D_ACK: begin
          // any scl fall ends the acknowledge
          if (scl_fall) begin
            bitc_r <= 4'h0;
            if (rw_r && bidx_r == BIDX_SUB) begin
              state_r <= D_TX;
              tx_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end else begin
              state_r <= D_RX;
              sda_oe_r <= 1'b0;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (bitc_r == LAST_TX_BIT) begin
              state_r <= D_MACK;
              sda_oe_r <= 1'b0;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
              bitc_r <= bitc_r + 4'h1;
            end
          end
        end
        D_MACK: begin
          // single byte only, whatever the master answers
          if (scl_fall) begin
            state_r <= D_IDLE;
          end
        end
        default: begin
          state_r <= D_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ************************************
  // channel registers
  // ************************************

  // no reset: power-up content is arbitrary
  always_ff @(posedge pclk) begin
    for (int i = 1; i <= 3; i++) begin
      if (wr_fire && sub_r == 8'(i)) begin
        ch_cfg[i] <= shreg_r;
      end
    end
  end

  // decoded per-channel controls
  always_ff @(posedge pclk) begin
    for (int i = 1; i <= 3; i++) begin
      ch_input_b[i] <= ch_cfg[i][MUX_BIT];
      ch_mode[i] <= ch_cfg[i][MODE_HI:MODE_LO];
      ch_enable[i] <= ch_cfg[i][MODE_HI:MODE_LO] != MODE_OFF;
      ch_mute[i] <= ch_cfg[i][MODE_HI:MODE_LO] == MODE_MUTE;
      sync_tip_clamp_mode[i] <= ch_cfg[i][MODE_HI:MODE_LO] >= MODE_STC_LO;
      ch_filter[i] <= filt_code(ch_cfg[i]);
    end
  end

  // write strobe and link status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_wr_pulse <= 1'b0;
      cfg_wr_ch <= 2'h0;
      dev_addressed <= 1'b0;
    end else begin
      cfg_wr_pulse <= wr_fire;
      if (wr_fire) begin
        cfg_wr_ch <= sub_r[1:0];
      end
      dev_addressed <= (state_r != D_IDLE) && !(state_r == D_RX && bidx_r == BIDX_ADDR);
    end
  end

endmodule // vaicc_dev
`default_nettype wire

// ### vaicc_host.sv
// controller end: apb command registers driving write and two-phase read
`timescale 1ns/1ps
`default_nettype none
module vaicc_host (
  // two-wire link
  vaicc_if.master bus,
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr
);
  import vaicc_pkg::*;

  // ************************************
  // helpers
  // ************************************

  // byte sent in a given slot
  function automatic logic [7:0] byte_of(input logic [1:0] idx, input logic ph2,
                                         input logic [1:0] tg, input logic [7:0] sb,
                                         input logic [7:0] wd);
    case (idx)
      BIDX_ADDR: byte_of = {ADDR_PREFIX, tg, ph2};
      BIDX_SUB: byte_of = sb;
      default: byte_of = wd;
    endcase
  endfunction

  // ************************************
  // command registers
  // ************************************
  vaicc_hst_t st_r;
  logic [7:0] sub_r;
  logic [7:0] wdat_r;
  logic [7:0] rdata_r;
  logic [1:0] tgt_r;
  logic rd_r;
  logic busy_r;
  logic nack_r;
  logic take;
  logic go;

  assign take = psel && penable && pready && pwrite;
  // a new command is refused while busy
  assign go = take && paddr == CMD_OFS && pwdata[CMD_GO_BIT] && !busy_r;

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= PRDATA_RST;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !(paddr == CMD_OFS || paddr == WDATA_OFS || paddr == STAT_OFS);
        case (paddr)
          CMD_OFS: prdata <= 32'({tgt_r, 1'b0, rd_r, sub_r});
          WDATA_OFS: prdata <= 32'(wdat_r);
          STAT_OFS: prdata <= 32'({rdata_r, 6'h00, nack_r, busy_r});
          default: prdata <= PRDATA_RST;
        endcase
      end
    end
  end

  // software-written settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_r <= 8'h00;
      wdat_r <= 8'h00;
      tgt_r <= 2'h0;
      rd_r <= 1'b0;
    end else if (take && !busy_r) begin
      if (paddr == CMD_OFS) begin
        sub_r <= pwdata[7:0];
        rd_r <= pwdata[CMD_RD_BIT];
        tgt_r <= pwdata[CMD_TGT_LO+1:CMD_TGT_LO];
      end
      if (paddr == WDATA_OFS) begin
        wdat_r <= pwdata[7:0];
      end
    end
  end

  // ************************************
  // link engine
  // ************************************
  logic [2:0] sda_ff_r;
  logic sda_s_r;
  logic zero_r;
  logic [7:0] cnt_r;
  logic [1:0] q_r;
  logic [3:0] bitc_r;
  logic [1:0] bidx_r;
  logic [7:0] txb_r;
  logic part2_r;
  logic flushed_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic qtick;
  logic rxmode;
  logic last;

  assign qtick = (st_r != H_IDLE) && (cnt_r == QTR_MAX);
  assign rxmode = part2_r && bidx_r == BIDX_SUB;
  assign last = rd_r ? (bidx_r == BIDX_SUB) : (bidx_r == BIDX_DATA);
  assign bus.scl_o = zero_r;
  assign bus.scl_oe = scl_oe_r;
  assign bus.sda_m_o = zero_r;
  assign bus.sda_m_oe = sda_oe_r;

  // sda sampling and quarter-period divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_ff_r <= SYNC_RST;
      sda_s_r <= 1'b1;
      zero_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      sda_ff_r <= {sda_ff_r[1:0], bus.sda};
      if (sda_ff_r[2] == sda_ff_r[1]) begin
        sda_s_r <= sda_ff_r[2];
      end
      zero_r <= 1'b0;
      cnt_r <= (st_r == H_IDLE || qtick) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  // start, bits, stop, each four quarters long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= H_IDLE;
      q_r <= 2'h0;
      bitc_r <= 4'h0;
      bidx_r <= BIDX_ADDR;
      txb_r <= 8'h00;
      rdata_r <= 8'h00;
      part2_r <= 1'b0;
      flushed_r <= 1'b0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      if (qtick) begin
        q_r <= q_r + 2'h1;
      end
      unique case (st_r)
        H_IDLE: begin
          q_r <= 2'h0;
          if (go) begin
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            part2_r <= 1'b0;
            bidx_r <= BIDX_ADDR;
            st_r <= flushed_r ? H_START : H_FLUSH;
          end
        end
        H_FLUSH: begin
          // one idle scl pulse before the first frame
          if (qtick) begin
            if (q_r == 2'h0) scl_oe_r <= 1'b1;
            if (q_r == 2'h2) scl_oe_r <= 1'b0;
            if (q_r == 2'h3) begin
              flushed_r <= 1'b1;
              st_r <= H_START;
            end
          end
        end
        H_START: begin
          if (qtick) begin
            if (q_r == 2'h1) sda_oe_r <= 1'b1;
            if (q_r == 2'h2) scl_oe_r <= 1'b1;
            if (q_r == 2'h3) begin
              st_r <= H_BIT;
              bitc_r <= 4'h0;
              txb_r <= byte_of(bidx_r, part2_r, tgt_r, sub_r, wdat_r);
            end
          end
        end
        H_BIT: begin
          if (qtick) begin
            unique case (q_r)
              2'h0: sda_oe_r <= (bitc_r != ACK_SLOT && !rxmode) ? ~txb_r[7] : 1'b0;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (bitc_r != ACK_SLOT && rxmode) rdata_r <= {rdata_r[6:0], sda_s_r};
                if (bitc_r == ACK_SLOT && !rxmode) nack_r <= sda_s_r;
              end
              2'h3: begin
                scl_oe_r <= 1'b1;
                if (bitc_r == ACK_SLOT) begin
                  bitc_r <= 4'h0;
                  if (nack_r || last) begin
                    st_r <= H_STOP;
                  end else begin
                    bidx_r <= bidx_r + 2'h1;
                    txb_r <= byte_of(bidx_r + 2'h1, part2_r, tgt_r, sub_r, wdat_r);
                  end
                end else begin
                  bitc_r <= bitc_r + 4'h1;
                  txb_r <= {txb_r[6:0], 1'b0};
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (qtick) begin
            if (q_r == 2'h0) sda_oe_r <= 1'b1;
            if (q_r == 2'h1) scl_oe_r <= 1'b0;
            if (q_r == 2'h2) sda_oe_r <= 1'b0;
            if (q_r == 2'h3) begin
              if (rd_r && !part2_r && !nack_r) begin
                part2_r <= 1'b1;
                bidx_r <= BIDX_ADDR;
                st_r <= H_START;
              end else begin
                busy_r <= 1'b0;
                st_r <= H_IDLE;
              end
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

endmodule // vaicc_host
`default_nettype wire

// ### vaicc_if.sv
// two-wire link between the controller and the channel configuration slave
`timescale 1ns/1ps
`default_nettype none
interface vaicc_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // pulled-up open-drain wires
  assign scl = !(scl_oe && !scl_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);

  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                  input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

// ### vaicc_link_monitor.sv
// link checker: slave drive timing, ack slots and framing
`timescale 1ns/1ps
`default_nettype none
module vaicc_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link drivers and wires
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  import vaicc_pkg::*;
  logic scl_q_r, sda_q_r, ign_r;
  logic [5:0] cnt_r;
  logic [7:0] sh_r;
  logic st_w, rs_w;
  // ********
  // frame tracking
  // ********
  // start and scl rise as seen on the wires
  assign st_w = scl && scl_q_r && sda_q_r && !sda;
  assign rs_w = scl && !scl_q_r;
  // rises since start, address byte, refused transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cnt_r <= 6'h00;
      sh_r <= 8'h00;
      ign_r <= 1'b0;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      if (st_w) begin
        cnt_r <= 6'h00;
        ign_r <= 1'b0;
      end else if (rs_w && cnt_r != 6'h3f) begin
        cnt_r <= cnt_r + 6'h01;
        if (cnt_r < 6'h08) sh_r <= {sh_r[6:0], sda};
        if (cnt_r == 6'h08 && !sda_s_oe) ign_r <= 1'b1;
      end
    end
  end
  // ********
  // assertions
  // ********
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  slave_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave sda moved while scl high");
  slave_low_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drove sda high");
  ack_slot_a: assert property (rs_w && sda_s_oe |->
    (sh_r[0] ? (cnt_r inside {[6'h08:6'h10]}) : (cnt_r inside {6'h08, 6'h11, 6'h1a})))
    else $error("slave drove sda outside its slots");
  addr_prefix_a: assert property (rs_w && cnt_r == 6'h08 && sda_s_oe |->
    sh_r[7:3] == ADDR_PREFIX) else $error("ack for a foreign prefix");
  ignore_rest_a: assert property (ign_r |-> !sda_s_oe)
    else $error("slave drove sda after refusing");
  ack_hold_a: assert property (rs_w && sda_s_oe |-> sda_s_oe [*8])
    else $error("slave let go while scl high");
  master_free_a: assert property (rs_w && sda_s_oe |-> !sda_m_oe)
    else $error("master drove sda in a slave slot");
  start_scl_a: assert property (st_w |-> ##[1:40] !scl)
    else $error("no scl fall after start");
endmodule // vaicc_link_monitor
`default_nettype wire

// ### vaicc_pkg.sv
// constants and types shared by both ends of the channel configuration link
package vaicc_pkg;

  // ************************************
  // link framing
  // ************************************
  localparam logic [4:0] ADDR_PREFIX = 5'h0b;
  localparam logic [7:0] SUB_CH1 = 8'h01;
  localparam logic [7:0] SUB_CH2 = 8'h02;
  localparam logic [7:0] SUB_CH3 = 8'h03;
  localparam logic [7:0] RD_BAD = 8'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [1:0] BIDX_ADDR = 2'h0;
  localparam logic [1:0] BIDX_SUB = 2'h1;
  localparam logic [1:0] BIDX_DATA = 2'h2;
  localparam logic [1:0] BIDX_OVER = 2'h3;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // ************************************
  // channel register fields
  // ************************************
  localparam int FILT_HI = 7;
  localparam int FILT_LO = 6;
  localparam int MUX_BIT = 5;
  localparam int MODE_HI = 2;
  localparam int MODE_LO = 0;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_MUTE = 3'h1;
  localparam logic [2:0] MODE_STC_LO = 3'h5;
  localparam logic [1:0] FILT_500K = 2'h0;
  localparam logic [1:0] FILT_2M5 = 2'h1;
  localparam logic [1:0] FILT_5M = 2'h2;
  localparam logic [1:0] FILT_NONE = 2'h3;

  // ************************************
  // controller registers and timing
  // ************************************
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] WDATA_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam int CMD_RD_BIT = 8;
  localparam int CMD_GO_BIT = 9;
  localparam int CMD_TGT_LO = 10;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_QTR_NS = 250;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] QTR_MAX = 8'(SCL_QTR_CYC - 1);

  typedef logic [3:1][7:0] vaicc_cfg_t;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RX = 5'h02,
    D_ACK = 5'h04,
    D_TX = 5'h08,
    D_MACK = 5'h10
  } vaicc_dst_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_FLUSH = 5'h02,
    H_START = 5'h04,
    H_BIT = 5'h08,
    H_STOP = 5'h10
  } vaicc_hst_t;

endpackage

// ### video_amp_i2c_channel_config_tb.sv
// self-checking bench: apb controller driving the channel slave over the link
`timescale 1ns/1ps
`default_nettype none
module video_amp_i2c_channel_config_tb;
  import vaicc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic addr_select_hi_pin, addr_select_lo_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  vaicc_cfg_t ch_cfg;
  logic [3:1][1:0] ch_filter;
  logic [3:1][2:0] ch_mode;
  logic [3:1] ch_input_b, ch_enable, ch_mute, sync_tip_clamp_mode;
  logic [7:0] exp_cfg [1:3];
  int mismatches, tests_run;
  logic cfg_wr_pulse, dev_addressed;
  logic [1:0] cfg_wr_ch;
  int wr_pulses = 0, addr_cycles = 0;
  // ********
  // both ends and the link checker
  // ********
  vaicc_if link ();
  vaicc_host u_vaicc_host (.bus(link), .pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  vaicc_dev u_vaicc_dev (.bus(link), .pclk, .presetn, .addr_select_hi_pin,
    .addr_select_lo_pin, .ch_cfg, .ch_filter, .ch_input_b, .ch_mode, .ch_enable, .ch_mute,
    .sync_tip_clamp_mode, .cfg_wr_pulse, .cfg_wr_ch, .dev_addressed);
  vaicc_link_monitor u_vaicc_link_monitor (.pclk, .presetn, .sda_m_oe(link.sda_m_oe),
    .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  // free-running clock
  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  // count write strobes and addressed cycles seen at the slave
  always @(posedge pclk) begin
    if (cfg_wr_pulse === 1'b1) wr_pulses++;
    if (dev_addressed === 1'b1) addr_cycles++;
  end
  // verdict and end of run
  task automatic finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // a wait that ran out
  task automatic hang();
    mismatches++;
    finish_test();
  endtask
  // compare one result
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) hang();
  endtask
  // command one link transfer and poll until idle
  task automatic xfer(input logic [1:0] tg, input logic rd, input logic [7:0] sub,
                      input logic [7:0] d, output logic [31:0] st);
    logic e;
    int n;
    n = 0;
    apb(1'b1, WDATA_OFS, {24'h00_0000, d}, st, e);
    apb(1'b1, CMD_OFS, {20'h0_0000, tg, 1'b1, rd, sub}, st, e);
    do begin
      apb(1'b0, STAT_OFS, 32'h0000_0000, st, e);
      n++;
    end while (st[0] !== 1'b0 && n < 3000);
    if (st[0] !== 1'b0) hang();
  endtask
  // all three channel registers against the model
  task automatic chk_regs();
    for (int c = 1; c <= 3; c++) begin
      chk("channel reg", 32'(exp_cfg[c]), 32'(ch_cfg[c]));
    end
  endtask
  // every mode code with filter and input choice
  task automatic t_modes();
    logic [31:0] st;
    logic [7:0] d;
    logic [2:0] m;
    int c;
    int n0;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      c = i % 3 + 1;
      d = {m[1:0] + 2'h3, m[0], m[2:1], m};
      n0 = wr_pulses;
      xfer(2'h2, 1'b0, 8'(c), d, st);
      exp_cfg[c] = d;
      chk("wr pulses", 32'h0000_0001, 32'(wr_pulses - n0));
      chk("wr channel", 32'(c), 32'(cfg_wr_ch));
      chk("nack", 32'h0000_0000, 32'(st[1]));
      chk_regs();
      chk("mode", 32'(m), 32'(ch_mode[c]));
      chk("on", 32'(m != MODE_OFF), 32'(ch_enable[c]));
      chk("mute", 32'(m == MODE_MUTE), 32'(ch_mute[c]));
      chk("clamp", 32'(m >= MODE_STC_LO), 32'(sync_tip_clamp_mode[c]));
      chk("input", 32'(d[5]), 32'(ch_input_b[c]));
      chk("filter", 32'(m < MODE_STC_LO ? FILT_NONE : (d[7] ? FILT_5M : d[7:6])),
        32'(ch_filter[c]));
      if (i > 4) begin
        xfer(2'h2, 1'b1, 8'(c), 8'h00, st);
        chk("read", 32'(d), 32'(st[15:8]));
      end
    end
  endtask
  // subaddresses outside 1 to 3 change nothing
  task automatic t_bad_sub();
    logic [31:0] st;
    int n0;
    n0 = wr_pulses;
    xfer(2'h2, 1'b0, 8'h81, 8'h5a, st);
    chk("nack", 32'h0000_0000, 32'(st[1]));
    xfer(2'h2, 1'b0, 8'h00, 8'ha5, st);
    chk_regs();
    chk("wr pulses", 32'h0000_0000, 32'(wr_pulses - n0));
    xfer(2'h2, 1'b1, 8'h04, 8'h00, st);
    chk("read", 32'(RD_BAD), 32'(st[15:8]));
  endtask
  // each pin setting: own address answered, neighbour refused
  task automatic t_pins();
    logic [31:0] st;
    int n0;
    for (int p = 0; p < 4; p++) begin
      @(posedge pclk);
      {addr_select_hi_pin, addr_select_lo_pin} <= 2'(p);
      n0 = addr_cycles;
      xfer(2'(p) ^ 2'h1, 1'b0, SUB_CH3, 8'hc3, st);
      chk("nack", 32'h0000_0001, 32'(st[1]));
      chk("addressed", 32'h0000_0000, 32'(addr_cycles - n0));
      xfer(2'(p), 1'b0, SUB_CH3, {2'h3, 3'(p), 3'h7}, st);
      exp_cfg[3] = {2'h3, 3'(p), 3'h7};
      chk("nack", 32'h0000_0000, 32'(st[1]));
      chk("addressed", 32'h0000_0001, 32'(addr_cycles > n0));
      chk("addressed end", 32'h0000_0000, 32'(dev_addressed));
      chk("filter", 32'(FILT_5M), 32'(ch_filter[3]));
      chk_regs();
    end
  endtask
  // reset mid-run keeps registers; unmapped apb address
  task automatic t_reset();
    logic [31:0] st;
    logic e;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_regs();
    xfer(2'h3, 1'b1, SUB_CH3, 8'h00, st);
    chk("read", 32'(exp_cfg[3]), 32'(st[15:8]));
    apb(1'b0, 12'h010, 32'h0000_0000, st, e);
    chk("slverr", 32'h0000_0001, 32'(e));
    chk("rdata", PRDATA_RST, st);
  endtask
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {addr_select_hi_pin, addr_select_lo_pin} = 2'h2;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_modes();
    t_bad_sub();
    t_pins();
    t_reset();
    finish_test();
  end
endmodule // video_amp_i2c_channel_config_tb
`default_nettype wire
